// file: hw/srvtl_entry_mem.v
// four-entry torque limit store with registered read data
`timescale 1ns/1ns
`default_nettype none
`include "srvtl_regs.vh"
module srvtl_entry_mem #(
    parameter WIDTH = 16,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    // clock and reset
    input wire clk_in,
    input wire nrst_in,
    // write port
    input wire wr_en_in,
    input wire [AW-1:0] wr_addr_in,
    input wire [WIDTH-1:0] wr_data_in,
    // read port
    input wire [AW-1:0] rd_addr_in,
    output reg [WIDTH-1:0] rd_data_out
);
    // storage words
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    genvar g;
    // ********************************************************************
    // storage
    // ********************************************************************
    generate
        for (g = 0; g < DEPTH; g = g + 1) begin : g_word
            // each word clears to zero and loads on its own address
            always @(posedge clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    mem_reg[g] <= `SRVTL_ENTRY_RESET;
                end else if (wr_en_in && (wr_addr_in == g)) begin
                    mem_reg[g] <= wr_data_in;
                end
            end
        end
    endgenerate
    // registered read
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rd_data_out <= {WIDTH{1'b0}};
        end else begin
            rd_data_out <= mem_reg[rd_addr_in];
        end
    end
endmodule // srvtl_entry_mem
`default_nettype wire

// file: hw/srvtl_regs.vh
// register map, field layouts, reset values and limits for the torque limit and absolute position block
`ifndef SRVTL_REGS_VH
`define SRVTL_REGS_VH
// ********************************************************************
// register byte offsets
// ********************************************************************
`define SRVTL_OFF_ENTRY0 12'h000
`define SRVTL_OFF_ENTRY1 12'h004
`define SRVTL_OFF_ENTRY2 12'h008
`define SRVTL_OFF_ENTRY3 12'h00C
`define SRVTL_OFF_GAIN 12'h010
`define SRVTL_OFF_OFFSET 12'h014
`define SRVTL_OFF_SYSCFG 12'h018
`define SRVTL_OFF_CTRL 12'h01C
`define SRVTL_OFF_STATUS 12'h020
`define SRVTL_OFF_ALARM 12'h024
`define SRVTL_OFF_ANALOG 12'h028
`define SRVTL_OFF_LIMIT 12'h02C
// ********************************************************************
// field positions
// ********************************************************************
`define SRVTL_SYS_ANALOG_EN 0
`define SRVTL_SYS_RESET_MODE 1
`define SRVTL_CTL_AUTO_OFS 0
`define SRVTL_CTL_APPLY_OFS 1
`define SRVTL_ALM_NO_BATT 0
`define SRVTL_ALM_ABS_UNSUP 1
`define SRVTL_ALM_RANGE 2
`define SRVTL_ALM_POS_LOSS 3
// ********************************************************************
// reset values and limits
// ********************************************************************
`define SRVTL_GAIN_RESET 16'h001E
`define SRVTL_GAIN_MAX 16'h012C
`define SRVTL_TORQUE_MAX 16'h012C
`define SRVTL_ENTRY_RESET 16'h0000
`define SRVTL_OFFSET_RESET 16'h0000
`define SRVTL_SYSCFG_RESET 2'h1
`define SRVTL_REV_MAX 32'h00007FFF
`define SRVTL_REV_MIN 32'hFFFF8000
`endif

// file: hw/srvtl_top.v
// torque limit selection, clamp and absolute position supervision with APB registers
// Functional notes
// - analog off: four stored entries by select
// - analog on: entry 0 from analog voltage
// - analog gain 0 to 300, default 30
// - manual offset subtracted from analog command
// - auto offset captures reading on command
// - system settings latched at power-up only
// - limit request clamps torque to entry
// - no request: torque ceiling 300 percent
// - limited flag when torque reaches limit
// - absolute switch latched at power-up, default off
// - absolute on, no battery: alarm
// - battery while absolute off: alarm
// - range overrun raises position range alarm
// - range alarm then reset or move: loss
// - absolute mode stored position lost: loss alarm
// - loss on battery first power, cable off
// - default: pulses blocked until position request
// - alternative: pulses enabled right after reset
// - absolute off: position not retained
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "srvtl_regs.vh"
module srvtl_top #(
    parameter TW = 16,
    parameter RESOLUTION = 32'd10000
) (
    // clock and reset
    input wire REF_CLK_IN,
    input wire NRST_IN,
    // apb slave
    input wire PSEL_IN,
    input wire PENABLE_IN,
    input wire PWRITE_IN,
    input wire [11:0] PADDR_IN,
    input wire [31:0] PWDATA_IN,
    output reg [31:0] PRDATA_OUT,
    output reg PREADY_OUT,
    output reg PSLVERR_OUT,
    // host discrete inputs
    input wire TORQUE_LIMIT_REQUEST_IN,
    input wire DATA_SELECT_LOW_IN,
    input wire DATA_SELECT_HIGH_IN,
    input wire POSITION_REQUEST_IN,
    input wire ALARM_RESET_IN,
    // straps and supervision inputs
    input wire ABSOLUTE_MODE_SWITCH_IN,
    input wire BATTERY_PRESENT_IN,
    input wire BATTERY_LOW_IN,
    input wire BATTERY_NEW_IN,
    input wire ENCODER_CABLE_OK_IN,
    input wire MOTOR_RUN_IN,
    input wire PULSE_IN,
    // analog reading in millivolts and motor torque in percent
    input wire signed [15:0] ANALOG_MV_IN,
    input wire [TW-1:0] TORQUE_DEMAND_IN,
    input wire signed [31:0] STEP_POS_IN,
    // outputs
    output reg [TW-1:0] TORQUE_CMD_OUT,
    output reg TORQUE_LIMITED_FLAG_OUT,
    output reg PULSE_ENABLE_OUT,
    output reg POSITION_RETAIN_OUT,
    output reg [3:0] ALARM_OUT
);
    // ********************************************************************
    // declarations
    // ********************************************************************
    // power-up latch states, one-hot
    localparam [1:0] ST_BOOT = 2'b01;
    localparam [1:0] ST_RUN = 2'b10;
    reg [1:0] state_reg;
    // software-written settings
    reg [15:0] gain_reg;
    reg signed [15:0] offset_reg;
    reg [1:0] syscfg_reg = `SRVTL_SYSCFG_RESET; // kept over reset, as if non-volatile
    reg auto_ofs_reg;
    // settings in force since power-up
    reg analog_en_reg;
    reg reset_mode_reg;
    reg abs_mode_reg;
    // alarms and pulse gating
    reg [3:0] alarm_reg;
    reg range_seen_reg;
    reg wait_preq_reg;
    reg alarm_reset_in_d_reg;
    reg preq_d_reg;
    // analog path
    reg [TW-1:0] analog_lim_reg;
    reg [TW-1:0] limit_reg;
    // entry store
    wire [1:0] sel;
    wire [TW-1:0] entry_rd;
    wire ent_wr;
    // apb phase decode
    wire wr_acc;
    wire rd_acc;
    // register read path
    reg [31:0] rd_mux;
    reg bad_addr;
    // analog arithmetic, millivolts times percent
    reg signed [31:0] diff;
    reg signed [47:0] prod;
    // scaled limit before the clamp
    reg signed [47:0] quot;
    // position range check in revolutions
    reg signed [31:0] revs;
    reg range_err;
    // edge detects on host lines
    wire alarm_reset_in_rise;
    wire preq_rise;
    // ********************************************************************
    // decoding helpers
    // ********************************************************************
    // true when the offset selects one of the four entry words
    function is_entry;
        input [11:0] a;
        begin
            is_entry = (a[11:4] == 8'h00);
        end
    endfunction
    assign wr_acc = PSEL_IN && PENABLE_IN && PWRITE_IN;
    assign rd_acc = PSEL_IN && !PENABLE_IN && !PWRITE_IN;
    assign ent_wr = wr_acc && PREADY_OUT && is_entry(PADDR_IN);
    assign sel = {DATA_SELECT_HIGH_IN, DATA_SELECT_LOW_IN};
    assign alarm_reset_in_rise = ALARM_RESET_IN && !alarm_reset_in_d_reg;
    assign preq_rise = POSITION_REQUEST_IN && !preq_d_reg;
    // ********************************************************************
    // entry store
    // ********************************************************************
    srvtl_entry_mem #(.WIDTH(TW), .DEPTH(4), .AW(2)) u_mem (
        .clk_in(REF_CLK_IN),
        .nrst_in(NRST_IN),
        .wr_en_in(ent_wr),
        .wr_addr_in(PADDR_IN[3:2]),
        .wr_data_in(PWDATA_IN[TW-1:0]),
        .rd_addr_in(sel),
        .rd_data_out(entry_rd)
    );
    // ********************************************************************
    // apb read mux
    // ********************************************************************
    always @* begin
        rd_mux = 32'h00000000;
        bad_addr = 1'b0;
        case (PADDR_IN)
            `SRVTL_OFF_GAIN: rd_mux = {16'h0000, gain_reg};
            `SRVTL_OFF_OFFSET: rd_mux = {{16{offset_reg[15]}}, offset_reg};
            `SRVTL_OFF_SYSCFG: rd_mux = {30'h00000000, syscfg_reg};
            `SRVTL_OFF_CTRL: rd_mux = {31'h00000000, auto_ofs_reg};
            `SRVTL_OFF_STATUS: rd_mux = {27'h0000000, abs_mode_reg, reset_mode_reg, analog_en_reg,
                                         wait_preq_reg, TORQUE_LIMITED_FLAG_OUT};
            `SRVTL_OFF_ALARM: rd_mux = {28'h0000000, alarm_reg};
            `SRVTL_OFF_LIMIT: rd_mux = {{(32-TW){1'b0}}, limit_reg};
            `SRVTL_OFF_ANALOG: rd_mux = {{(32-TW){1'b0}}, analog_lim_reg};
            default: begin
                // entries are write-only here and read through the select path; others fault
                bad_addr = !is_entry(PADDR_IN);
            end
        endcase
    end
    // apb: answer in the access phase, one cycle after setup
    always @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            PRDATA_OUT <= 32'h00000000;
            PREADY_OUT <= 1'b0;
            PSLVERR_OUT <= 1'b0;
        end else begin
            PREADY_OUT <= PSEL_IN && !PENABLE_IN;
            PSLVERR_OUT <= PSEL_IN && !PENABLE_IN && bad_addr;
            // read data captured at the setup edge
            if (rd_acc) begin
                PRDATA_OUT <= rd_mux;
            end
        end
    end
    // ********************************************************************
    // software settings
    // ********************************************************************
    always @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            gain_reg <= `SRVTL_GAIN_RESET;
            offset_reg <= `SRVTL_OFFSET_RESET;
            auto_ofs_reg <= 1'b0;
        end else begin
            if (wr_acc && PREADY_OUT) begin
                case (PADDR_IN)
                    `SRVTL_OFF_GAIN: begin
                        // out-of-range gains saturate at the top of range
                        if (PWDATA_IN[15:0] > `SRVTL_GAIN_MAX) begin
                            gain_reg <= `SRVTL_GAIN_MAX;
                        end else begin
                            gain_reg <= PWDATA_IN[15:0];
                        end
                    end
                    `SRVTL_OFF_OFFSET: offset_reg <= PWDATA_IN[15:0];
                    `SRVTL_OFF_CTRL: begin
                        auto_ofs_reg <= PWDATA_IN[`SRVTL_CTL_AUTO_OFS];
                        // apply-offset: capture present reading as zero point
                        if (PWDATA_IN[`SRVTL_CTL_APPLY_OFS] && PWDATA_IN[`SRVTL_CTL_AUTO_OFS]) begin
                            offset_reg <= ANALOG_MV_IN;
                        end
                    end
                    default: begin
                        // nothing else is writable here
                    end
                endcase
            end
        end
    end
    // ********************************************************************
    // stored system settings
    // ********************************************************************
    // kept across a reset, which stands for a power cycle; read only at boot
    always @(posedge REF_CLK_IN) begin
        if (wr_acc && PREADY_OUT && (PADDR_IN == `SRVTL_OFF_SYSCFG)) begin
            syscfg_reg <= PWDATA_IN[1:0];
        end
    end
    // ********************************************************************
    // power-up latch of system settings and the absolute switch
    // ********************************************************************
    // straps are caught by a clocked step after reset release
    always @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            state_reg <= ST_BOOT;
            analog_en_reg <= 1'b1;
            reset_mode_reg <= 1'b0;
            abs_mode_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_BOOT: begin
                    // catch settings and strap once
                    analog_en_reg <= syscfg_reg[`SRVTL_SYS_ANALOG_EN];
                    reset_mode_reg <= syscfg_reg[`SRVTL_SYS_RESET_MODE];
                    abs_mode_reg <= ABSOLUTE_MODE_SWITCH_IN;
                    state_reg <= ST_RUN;
                end
                ST_RUN: begin
                    // held until the next power cycle
                    state_reg <= ST_RUN;
                end
                default: state_reg <= ST_BOOT;
            endcase
        end
    end
    // ********************************************************************
    // analog limit and torque clamp
    // ********************************************************************
    // analog difference, product and revolutions
    always @* begin
        diff = {{16{ANALOG_MV_IN[15]}}, ANALOG_MV_IN} - {{16{offset_reg[15]}}, offset_reg};
        prod = diff * $signed({1'b0, gain_reg}); // percent times millivolt
        quot = prod / 1000;
        revs = STEP_POS_IN / $signed(RESOLUTION);
        range_err = (revs > $signed(`SRVTL_REV_MAX)) || (revs < $signed(`SRVTL_REV_MIN));
    end
    always @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            analog_lim_reg <= {TW{1'b0}};
            limit_reg <= `SRVTL_TORQUE_MAX;
            TORQUE_CMD_OUT <= {TW{1'b0}};
            TORQUE_LIMITED_FLAG_OUT <= 1'b0;
        end else begin
            // gain in percent per volt, reading in millivolts
            if (prod <= 0) begin
                analog_lim_reg <= {TW{1'b0}};
            end else if (prod >= $signed({32'h00000000, `SRVTL_TORQUE_MAX}) * 1000) begin
                analog_lim_reg <= `SRVTL_TORQUE_MAX;
            end else begin
                analog_lim_reg <= quot[TW-1:0];
            end
            // limit chosen from request, select and mode
            if (!TORQUE_LIMIT_REQUEST_IN) begin
                limit_reg <= `SRVTL_TORQUE_MAX;
            end else if (analog_en_reg && (sel == 2'h0)) begin
                limit_reg <= analog_lim_reg;
            end else if (entry_rd > `SRVTL_TORQUE_MAX) begin
                limit_reg <= `SRVTL_TORQUE_MAX;
            end else begin
                limit_reg <= entry_rd;
            end
            // torque command follows demand below the limit
            if (TORQUE_DEMAND_IN >= limit_reg) begin
                TORQUE_CMD_OUT <= limit_reg;
            end else begin
                TORQUE_CMD_OUT <= TORQUE_DEMAND_IN;
            end
            TORQUE_LIMITED_FLAG_OUT <= TORQUE_LIMIT_REQUEST_IN && (TORQUE_DEMAND_IN >= limit_reg);
        end
    end
    // ********************************************************************
    // absolute position alarms and pulse gating
    // ********************************************************************
    always @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            alarm_reg <= 4'h0;
            range_seen_reg <= 1'b0;
            wait_preq_reg <= 1'b0;
            alarm_reset_in_d_reg <= 1'b0;
            preq_d_reg <= 1'b0;
            PULSE_ENABLE_OUT <= 1'b0;
            POSITION_RETAIN_OUT <= 1'b0;
            ALARM_OUT <= 4'h0;
        end else begin
            // one-cycle delay for edge detects
            alarm_reset_in_d_reg <= ALARM_RESET_IN;
            preq_d_reg <= POSITION_REQUEST_IN;
            POSITION_RETAIN_OUT <= abs_mode_reg && (state_reg == ST_RUN);
            if (state_reg == ST_RUN) begin
                // battery checks, continuously evaluated
                alarm_reg[`SRVTL_ALM_NO_BATT] <= abs_mode_reg && !BATTERY_PRESENT_IN;
                alarm_reg[`SRVTL_ALM_ABS_UNSUP] <= !abs_mode_reg && BATTERY_PRESENT_IN;
                // range alarm: set wins over reset
                if (range_err) begin
                    alarm_reg[`SRVTL_ALM_RANGE] <= 1'b1;
                    range_seen_reg <= 1'b1;
                end else if (alarm_reset_in_rise) begin
                    alarm_reg[`SRVTL_ALM_RANGE] <= 1'b0;
                end
                // position loss sources; set wins over the reset
                if ((range_seen_reg && (alarm_reset_in_rise || MOTOR_RUN_IN)) ||
                    (abs_mode_reg && (BATTERY_LOW_IN || BATTERY_NEW_IN || !ENCODER_CABLE_OK_IN)) ||
                    (wait_preq_reg && PULSE_IN)) begin
                    alarm_reg[`SRVTL_ALM_POS_LOSS] <= 1'b1;
                    range_seen_reg <= 1'b0;
                    wait_preq_reg <= 1'b0;
                end else if (alarm_reset_in_rise && alarm_reg[`SRVTL_ALM_POS_LOSS]) begin
                    alarm_reg[`SRVTL_ALM_POS_LOSS] <= 1'b0;
                    wait_preq_reg <= !reset_mode_reg;
                end else if (preq_rise) begin
                    wait_preq_reg <= 1'b0;
                end
            end
            // pulses pass only with no alarm and no wait
            PULSE_ENABLE_OUT <= (alarm_reg == 4'h0) && !wait_preq_reg;
            ALARM_OUT <= alarm_reg;
        end
    end
endmodule // srvtl_top
`default_nettype wire

// file: tb/srvtl_host_model.sv
// host controller model driving the discrete request lines
`timescale 1ns/1ns
`default_nettype none
module srvtl_host_model (
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // requests from the bench
    input wire logic tl_req_in,
    input wire logic [1:0] sel_req_in,
    input wire logic preq_req_in,
    input wire logic arst_req_in,
    // discrete lines
    output logic tl_out,
    output logic dsl_out,
    output logic dsh_out,
    output logic preq_out,
    output logic arst_out
);
    // ********************************************************************
    // output stage, updated once per scan
    // ********************************************************************
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            {tl_out, dsl_out, dsh_out, preq_out, arst_out} <= 5'h00;
        end else begin
            tl_out <= tl_req_in;
            dsl_out <= sel_req_in[0];
            dsh_out <= sel_req_in[1];
            preq_out <= preq_req_in;
            arst_out <= arst_req_in;
        end
    end
endmodule // srvtl_host_model
`default_nettype wire

// file: tb/srvtl_top_check_assertions.sv
// port level checks for the torque limit and absolute position block
`timescale 1ns/1ns
`default_nettype none
module srvtl_top_check #(
    parameter TW = 16
) (
    // clock and reset
    input wire logic REF_CLK_IN,
    input wire logic NRST_IN,
    // apb
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [11:0] PADDR_IN,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic PREADY_OUT,
    input wire logic PSLVERR_OUT,
    // torque path
    input wire logic TORQUE_LIMIT_REQUEST_IN,
    input wire logic [TW-1:0] TORQUE_DEMAND_IN,
    input wire logic [TW-1:0] TORQUE_CMD_OUT,
    input wire logic TORQUE_LIMITED_FLAG_OUT,
    // supervision
    input wire logic BATTERY_PRESENT_IN,
    input wire logic signed [31:0] STEP_POS_IN,
    input wire logic POSITION_RETAIN_OUT,
    input wire logic PULSE_ENABLE_OUT,
    input wire logic [3:0] ALARM_OUT
);
    // ********************************************************************
    // assertions
    // ********************************************************************
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!NRST_IN);
    // setup phase is answered in the very next cycle, for one cycle only
    apb_ready_a: assert property (PSEL_IN && !PENABLE_IN |=> PREADY_OUT ##1 !PREADY_OUT)
        else $error("ready missing or too long");
    // unmapped read gives an error and zero data
    apb_slverr_a: assert property (PSEL_IN && !PENABLE_IN && !PWRITE_IN && PADDR_IN > 12'h02C
        |=> PSLVERR_OUT && PRDATA_OUT == 32'h0) else $error("unmapped read not refused");
    torque_ceiling_a: assert property (TORQUE_CMD_OUT <= 16'h012C)
        else $error("torque above ceiling");
    // without a request a settled demand passes through unchanged
    demand_pass_a: assert property ((!TORQUE_LIMIT_REQUEST_IN && TORQUE_DEMAND_IN <= 16'h012C
        && $stable(TORQUE_DEMAND_IN))[*5] |-> TORQUE_CMD_OUT == TORQUE_DEMAND_IN) else $error("demand altered");
    flag_quiet_a: assert property ((!TORQUE_LIMIT_REQUEST_IN && TORQUE_DEMAND_IN < 16'h012C
        && $stable(TORQUE_DEMAND_IN))[*5] |-> !TORQUE_LIMITED_FLAG_OUT) else $error("flag without limit");
    no_battery_a: assert property ((POSITION_RETAIN_OUT && !BATTERY_PRESENT_IN)[*4] |-> ALARM_OUT[0])
        else $error("missing battery alarm");
    range_alarm_a: assert property (STEP_POS_IN >= 32'sd400000000
        |-> ##[1:3] ALARM_OUT[2]) else $error("range alarm missing");
    loss_gate_a: assert property (ALARM_OUT[3] |-> !PULSE_ENABLE_OUT)
        else $error("pulses enabled during loss");
endmodule // srvtl_top_check
bind srvtl_top srvtl_top_check #(.TW(TW)) u_check (.REF_CLK_IN(REF_CLK_IN), .NRST_IN(NRST_IN),
    .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
    .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
    .TORQUE_LIMIT_REQUEST_IN(TORQUE_LIMIT_REQUEST_IN), .TORQUE_DEMAND_IN(TORQUE_DEMAND_IN),
    .TORQUE_CMD_OUT(TORQUE_CMD_OUT), .TORQUE_LIMITED_FLAG_OUT(TORQUE_LIMITED_FLAG_OUT),
    .BATTERY_PRESENT_IN(BATTERY_PRESENT_IN), .STEP_POS_IN(STEP_POS_IN),
    .POSITION_RETAIN_OUT(POSITION_RETAIN_OUT), .PULSE_ENABLE_OUT(PULSE_ENABLE_OUT), .ALARM_OUT(ALARM_OUT));
`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench for the torque limit and absolute position block
`timescale 1ns/1ns
`default_nettype none
`include "srvtl_regs.vh"
module tb_top;
    // ********************************************************************
    // stimulus, reference model and comparisons
    // ********************************************************************
    logic clk, nrst, psel, penable, pwrite, h_tl, h_preq, h_arst, abs_sw, batt, pulse, e, run;
    logic pready, pslverr, flag, pen, retain, tl, dsl, dsh, preq, arst;
    logic [1:0] h_sel;
    logic [2:0] trig;
    logic [3:0] alarm;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [15:0] demand, cmd;
    logic signed [15:0] mv;
    logic signed [31:0] step;
    int error_cnt, checks, seed, gain, ofs, i, k, lim;
    int ent[4];
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    srvtl_host_model host (.clk_in(clk), .nrst_in(nrst), .tl_req_in(h_tl), .sel_req_in(h_sel),
        .preq_req_in(h_preq), .arst_req_in(h_arst), .tl_out(tl), .dsl_out(dsl), .dsh_out(dsh),
        .preq_out(preq), .arst_out(arst));
    srvtl_top DUT (.REF_CLK_IN(clk), .NRST_IN(nrst), .PSEL_IN(psel), .PENABLE_IN(penable),
        .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .TORQUE_LIMIT_REQUEST_IN(tl),
        .DATA_SELECT_LOW_IN(dsl), .DATA_SELECT_HIGH_IN(dsh), .POSITION_REQUEST_IN(preq),
        .ALARM_RESET_IN(arst), .ABSOLUTE_MODE_SWITCH_IN(abs_sw), .BATTERY_PRESENT_IN(batt),
        .BATTERY_LOW_IN(trig[0]), .BATTERY_NEW_IN(trig[1]), .ENCODER_CABLE_OK_IN(!trig[2]),
        .MOTOR_RUN_IN(run), .PULSE_IN(pulse), .ANALOG_MV_IN(mv), .TORQUE_DEMAND_IN(demand),
        .STEP_POS_IN(step), .TORQUE_CMD_OUT(cmd), .TORQUE_LIMITED_FLAG_OUT(flag),
        .PULSE_ENABLE_OUT(pen), .POSITION_RETAIN_OUT(retain), .ALARM_OUT(alarm));
    // clamp of the analog limit to the torque range
    function automatic int clamp(input int v);
        return v < 0 ? 0 : (v > 300 ? 300 : v);
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; result left in r and e
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk);
        end
        if (n == 50) begin
            error_cnt++;
            finish_test;
        end
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task settle;
        repeat (6) @(posedge clk);
        @(negedge clk);
    endtask
    task alarm_clear;
        @(posedge clk);
        h_arst <= 1;
        repeat (3) @(posedge clk);
        h_arst <= 0;
        settle;
    endtask
    // power cycle with the given absolute mode strap
    task pwr(input logic sw);
        @(posedge clk);
        nrst <= 0;
        abs_sw <= sw;
        repeat (3) @(posedge clk);
        nrst <= 1;
        settle;
    endtask
    task finish_test;
        if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #1000000;
        error_cnt++;
        finish_test;
    end
    initial begin
        seed = 66;
        {psel, penable, pwrite, h_tl, h_preq, h_arst, pulse, abs_sw, batt, nrst, run} = '0;
        {h_sel, trig, paddr, pwdata, mv, step, demand} = '0;
        repeat (20) @(posedge clk);
        nrst <= 1;
        apb(0, `SRVTL_OFF_GAIN, 0);
        chk(r, 30);
        apb(1, `SRVTL_OFF_GAIN, 400);
        apb(0, `SRVTL_OFF_GAIN, 0);
        chk(r, 300);
        gain = ($random(seed) & 32'hFF) + 20;
        apb(1, `SRVTL_OFF_GAIN, gain);
        for (i = 0; i < 4; i++) begin
            ent[i] = ($random(seed) & 32'h7FFFFFFF) % 301;
            apb(1, 12'(`SRVTL_OFF_ENTRY0 + 4 * i), ent[i]);
        end
        apb(1, `SRVTL_OFF_OFFSET, 1000);
        mv <= 16'sd3000;
        settle;
        apb(0, `SRVTL_OFF_ANALOG, 0);
        chk(r, clamp(gain * 2));
        mv <= 16'sd1234;
        settle;
        apb(1, `SRVTL_OFF_CTRL, 3);
        ofs = 1234;
        mv <= 16'sd3234;
        settle;
        apb(0, `SRVTL_OFF_ANALOG, 0);
        chk(r, clamp(gain * 2));
        apb(1, `SRVTL_OFF_SYSCFG, 0);
        apb(0, `SRVTL_OFF_STATUS, 0);
        chk(r[2], 1);
        h_tl <= 1;
        for (i = 0; i < 12; i++) begin
            h_sel <= i[1:0];
            demand <= 16'(($random(seed) & 32'h7FFFFFFF) % 301);
            settle;
            lim = (i % 4 == 0) ? clamp(gain * (int'(mv) - ofs) / 1000) : ent[i % 4];
            chk(cmd, demand < lim ? demand : lim);
            chk(flag, demand >= lim);
            @(posedge clk);
        end
        mv <= 16'sd30000;
        settle;
        apb(0, `SRVTL_OFF_ANALOG, 0);
        chk(r, 300);
        h_tl <= 0;
        demand <= 16'h0190;
        settle;
        chk(cmd, 300);
        apb(0, 12'h030, 0);
        chk(r, 0);
        chk(e, 1);
        batt <= 1;
        pwr(1);
        chk(retain, 1);
        chk(alarm, 0);
        for (k = 0; k < 3; k++) begin
            @(posedge clk);
            trig <= 3'(1 << k);
            settle;
            chk(alarm[3], 1);
            chk(pen, 0);
            @(posedge clk);
            trig <= 0;
            alarm_clear;
            chk(alarm[3], 0);
            @(posedge clk);
            pulse <= 1;
            @(posedge clk);
            pulse <= 0;
            settle;
            chk(alarm[3], 1);
            alarm_clear;
        end
        @(posedge clk);
        h_preq <= 1;
        settle;
        chk(pen, 1);
        @(posedge clk);
        h_preq <= 0;
        batt <= 0;
        settle;
        chk(alarm[0], 1);
        apb(1, `SRVTL_OFF_SYSCFG, 2);
        batt <= 1;
        pwr(0);
        chk(alarm[1], 1);
        chk(retain, 0);
        @(posedge clk);
        batt <= 0;
        for (k = 0; k < 2; k++) begin
            @(posedge clk);
            run <= 0;
            step <= 32'sd400000000;
            settle;
            chk(alarm[2], 1);
            @(posedge clk);
            step <= 0;
            run <= k == 0;
            settle;
            chk(alarm[3], k == 0);
            alarm_clear;
            chk(alarm[3:2], k ? 2'b10 : 2'b00);
            chk(pen, k == 0);
        end
        apb(1, `SRVTL_OFF_ENTRY0, 32'h00000055);
        h_sel <= 0;
        h_tl <= 1;
        settle;
        chk(cmd, 32'h00000055);
        finish_test;
    end
endmodule // tb_top
`default_nettype wire
